// File: core/dtm_regs.svh
`ifndef DTM_REGS_SVH
`define DTM_REGS_SVH
`define DTM_CLK_PS  40000
`define DTM_ADR_PS  20000
`define DTM_ADR_CYC ((`DTM_ADR_PS) / (`DTM_CLK_PS))
`define DTM_MRZ_PS  1500
`define DTM_MRZ_CYC (((`DTM_MRZ_PS) + (`DTM_CLK_PS) - 1) / (`DTM_CLK_PS))
`define DTM_ODT_PS  20000
`define DTM_ODT_CYC (((`DTM_ODT_PS) + (`DTM_CLK_PS) - 1) / (`DTM_CLK_PS))
`define DTM_WLO_PS  20000
`define DTM_WLO_CYC ((`DTM_WLO_PS) / (`DTM_CLK_PS))
`define DTM_CNT_W   4
`define DTM_MIN1(x) (((x) < 1) ? 1 : (x))
`endif

// File: core/dtm_pkg.sv
package dtm_pkg;
    typedef enum logic [1:0] {
        DTM_IDLE,
        DTM_TRAIN,
        DTM_EXIT
    } dtm_state_t;
endpackage

// File: core/dtm_delay.sv
`timescale 1ns/100ps
`include "dtm_regs.svh"
// down-counter: done pulses when the loaded count has expired
module dtm_delay (
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  rstn,
    // control
    input  wire logic                  start,
    input  wire logic [`DTM_CNT_W-1:0] count,
    output logic                       busy,
    output logic                       done
);
    logic [`DTM_CNT_W-1:0] cnt_ff;
    logic [`DTM_CNT_W-1:0] nxt_cnt;
    logic                  done_ff;
    logic                  nxt_done;

    always_comb begin
        nxt_cnt  = cnt_ff;
        nxt_done = 1'b0;
        if (start) begin
            nxt_cnt = count;
        end else if (cnt_ff != '0) begin
            nxt_cnt  = cnt_ff - 1'b1;
            nxt_done = (cnt_ff == `DTM_CNT_W'(1));
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            cnt_ff  <= '0;
            done_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            done_ff <= nxt_done;
        end
    end

    assign busy = (cnt_ff != '0);
    assign done = done_ff;
endmodule

// File: core/dtm_core.sv
`timescale 1ns/100ps
`include "dtm_regs.svh"
// device side of command bus training and write leveling feedback
module dtm_core
    import dtm_pkg::*;
(
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rstn,
    // pins from controller
    input  wire logic       cke_pin,
    input  wire logic       cs_pin,
    input  wire logic [6:0] ca_pin,
    input  wire logic       dqs_pin,
    // mode select from mode register decode
    input  wire logic       cbt_mode,
    input  wire logic       wl_mode,
    // data lines
    output logic [6:0]      dq_out,
    output logic [6:0]      dq_oe_n,
    // termination
    output logic            odt_on
);
    localparam logic [`DTM_CNT_W-1:0] ADR_CNT =
        `DTM_CNT_W'(`DTM_MIN1(`DTM_ADR_CYC));
    localparam logic [`DTM_CNT_W-1:0] MRZ_CNT =
        `DTM_CNT_W'(`DTM_MIN1(`DTM_MRZ_CYC));
    localparam logic [`DTM_CNT_W-1:0] ODT_CNT =
        `DTM_CNT_W'(`DTM_MIN1(`DTM_ODT_CYC));
    localparam logic [`DTM_CNT_W-1:0] WLO_CNT =
        `DTM_CNT_W'(`DTM_MIN1(`DTM_WLO_CYC));

    // sync flops rest at the pins' idle levels: cke high, cs and dqs low,
    // so that no false edge is seen right after reset
    localparam logic [9:0] PIN_IDLE = 10'h200;

    // two-flop synchronisers for all pins
    logic [9:0] s1_ff;
    logic [9:0] s2_ff;
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            s1_ff <= PIN_IDLE;
            s2_ff <= PIN_IDLE;
        end else begin
            s1_ff <= {cke_pin, cs_pin, ca_pin, dqs_pin};
            s2_ff <= s1_ff;
        end
    end
    logic       cke_s;
    logic       cs_s;
    logic [6:0] ca_s;
    logic       dqs_s;
    assign cke_s = s2_ff[9];
    assign cs_s  = s2_ff[8];
    assign ca_s  = s2_ff[7:1];
    assign dqs_s = s2_ff[0];

    dtm_state_t st_ff;
    dtm_state_t nxt_st;
    logic       cke_d_ff;
    logic       nxt_cke_d;
    logic       cs_d_ff;
    logic       nxt_cs_d;
    logic       dqs_d_ff;
    logic       nxt_dqs_d;
    logic [6:0] smp_ff;
    logic [6:0] nxt_smp;
    logic [6:0] dq_ff;
    logic [6:0] nxt_dq;
    logic       oe_ff;
    logic       nxt_oe;
    logic       odt_ff;
    logic       nxt_odt;
    logic       odt_tgt_ff;
    logic       nxt_odt_tgt;
    logic       wl_lvl_ff;
    logic       nxt_wl_lvl;

    logic cke_fall;
    logic cke_rise;
    logic cs_rise;
    logic dqs_rise;
    assign cke_fall = cke_d_ff & ~cke_s;
    assign cke_rise = ~cke_d_ff & cke_s;
    assign cs_rise  = ~cs_d_ff & cs_s;
    assign dqs_rise = ~dqs_d_ff & dqs_s;

    // sample timer: a new sample restarts it; with a count of 1 every sample lands in turn
    logic adr_done;
    dtm_delay u_adr (
        .core_clk (core_clk),
        .rstn     (rstn),
        .start    (st_ff == DTM_TRAIN && cs_rise),
        .count    (ADR_CNT),
        .busy     (),
        .done     (adr_done)
    );
    // release timer after cke rises
    logic mrz_done;
    dtm_delay u_mrz (
        .core_clk (core_clk),
        .rstn     (rstn),
        .start    (st_ff == DTM_TRAIN && cke_rise),
        .count    (MRZ_CNT),
        .busy     (),
        .done     (mrz_done)
    );
    // termination switch delay
    logic odt_done;
    dtm_delay u_odt (
        .core_clk (core_clk),
        .rstn     (rstn),
        .start    (cbt_mode && (cke_fall || cke_rise)),
        .count    (ODT_CNT),
        .busy     (),
        .done     (odt_done)
    );
    // leveling feedback delay
    logic wlo_done;
    dtm_delay u_wlo (
        .core_clk (core_clk),
        .rstn     (rstn),
        .start    (wl_mode && dqs_rise),
        .count    (WLO_CNT),
        .busy     (),
        .done     (wlo_done)
    );

    always_comb begin
        nxt_st      = st_ff;
        nxt_cke_d   = cke_s;
        nxt_cs_d    = cs_s;
        nxt_dqs_d   = dqs_s;
        nxt_smp     = smp_ff;
        nxt_dq      = dq_ff;
        nxt_oe      = oe_ff;
        nxt_odt     = odt_ff;
        nxt_odt_tgt = odt_tgt_ff;
        nxt_wl_lvl  = wl_lvl_ff;
        unique case (st_ff)
            DTM_IDLE: begin
                if (cbt_mode && cke_fall) begin
                    nxt_st = DTM_TRAIN;
                end
            end
            DTM_TRAIN: begin
                // a later cs rise overwrites the held sample
                if (cs_rise) begin
                    nxt_smp = ca_s;
                end
                if (adr_done) begin
                    nxt_dq = smp_ff;
                    nxt_oe = 1'b1;
                end
                if (cke_rise) begin
                    nxt_st = DTM_EXIT;
                end
            end
            DTM_EXIT: begin
                // dq keeps the last result until the release timer ends
                if (mrz_done) begin
                    nxt_oe = 1'b0;
                    nxt_st = DTM_IDLE;
                end
            end
            default: begin
                nxt_st = DTM_IDLE;
            end
        endcase
        // termination target follows cke edges only while cbt_mode is set, in any state
        if (cbt_mode && cke_fall) begin
            nxt_odt_tgt = 1'b1;
        end else if (cbt_mode && cke_rise) begin
            nxt_odt_tgt = 1'b0;
        end
        if (odt_done) begin
            nxt_odt = odt_tgt_ff;
        end
        if (dqs_rise && wl_mode) begin
            nxt_wl_lvl = 1'b1;
        end else if (!wl_mode) begin
            // leaving leveling forgets the last report
            nxt_wl_lvl = 1'b0;
        end
        // leveling report, and release of the lines once idle
        if (wl_mode && wlo_done) begin
            nxt_dq = {7{wl_lvl_ff}};
            nxt_oe = 1'b1;
        end else if (!wl_mode && st_ff == DTM_IDLE) begin
            nxt_oe = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            st_ff      <= DTM_IDLE;
            cke_d_ff   <= 1'b1;
            cs_d_ff    <= 1'b0;
            dqs_d_ff   <= 1'b0;
            smp_ff     <= '0;
            dq_ff      <= '0;
            oe_ff      <= 1'b0;
            odt_ff     <= 1'b0;
            odt_tgt_ff <= 1'b0;
            wl_lvl_ff  <= 1'b0;
        end else begin
            st_ff      <= nxt_st;
            cke_d_ff   <= nxt_cke_d;
            cs_d_ff    <= nxt_cs_d;
            dqs_d_ff   <= nxt_dqs_d;
            smp_ff     <= nxt_smp;
            dq_ff      <= nxt_dq;
            oe_ff      <= nxt_oe;
            odt_ff     <= nxt_odt;
            odt_tgt_ff <= nxt_odt_tgt;
            wl_lvl_ff  <= nxt_wl_lvl;
        end
    end

    assign dq_out  = dq_ff;
    assign dq_oe_n = {7{~oe_ff}};
    assign odt_on  = odt_ff;
endmodule

// File: testbench/dtm_core_chk.sv
`timescale 1ns/100ps
module dtm_core_chk (
    // clock and reset
    input wire logic       core_clk,
    input wire logic       rstn,
    // controller pins and modes
    input wire logic       cke_pin,
    input wire logic       cs_pin,
    input wire logic [6:0] ca_pin,
    input wire logic       dqs_pin,
    input wire logic       cbt_mode,
    input wire logic       wl_mode,
    // device outputs
    input wire logic [6:0] dq_out,
    input wire logic [6:0] dq_oe_n,
    input wire logic       odt_on
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    a_odt_on_late: assert property (
        $rose(odt_on) |-> !cke_pin && !$past(cke_pin))
        else $error("termination on too early");
    a_odt_off_late: assert property (
        $fell(odt_on) |-> cke_pin && $past(cke_pin))
        else $error("termination off too early");
    a_odt_follows_cke: assert property (
        cbt_mode && $fell(cke_pin) |-> ##[1:6] odt_on)
        else $error("termination never on");
    a_sample_echo: assert property (
        cbt_mode && !cke_pin && $rose(cs_pin) ##1 !cs_pin [*6]
        |-> dq_out == $past(ca_pin, 6) && dq_oe_n == 7'h00)
        else $error("sample result wrong");
    a_dq_release: assert property (
        cbt_mode && $rose(cke_pin) && dq_oe_n == 7'h00
        |=> dq_oe_n == 7'h00 ##[1:5] dq_oe_n == 7'h7f)
        else $error("data release timing wrong");
    a_level_report: assert property (
        wl_mode && $rose(dqs_pin)
        |-> ##[2:6] dq_out == 7'h7f && dq_oe_n == 7'h00)
        else $error("leveling feedback missing");
endmodule
bind dtm_core dtm_core_chk u_chk (.core_clk, .rstn, .cke_pin, .cs_pin,
    .ca_pin, .dqs_pin, .cbt_mode, .wl_mode, .dq_out, .dq_oe_n, .odt_on);

// File: testbench/dtm_ctrl_model.sv
`timescale 1ns/100ps
module dtm_ctrl_model (
    // clock
    input wire logic  core_clk,
    // pins toward the device
    output logic       cke_pin,
    output logic       cs_pin,
    output logic [6:0] ca_pin,
    output logic       dqs_pin,
    // decoded mode bits
    output logic       cbt_mode,
    output logic       wl_mode
);
    localparam int ENTRY_CYC = (250 + 39) / 40;
    initial begin
        cke_pin = 1'b1;
        cs_pin = 1'b0;
        ca_pin = 7'h00;
        dqs_pin = 1'b0;
        cbt_mode = 1'b0;
        wl_mode = 1'b0;
    end
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic set_mode(input logic cbt, input logic wl);
        wait_cyc(1);
        cbt_mode <= cbt;
        wl_mode <= wl;
        wait_cyc(10);
    endtask
    task automatic cbt_enter();
        wait_cyc(1);
        dqs_pin <= 1'b0;
        wait_cyc(1);
        cke_pin <= 1'b0;
        wait_cyc(ENTRY_CYC);
    endtask
    task automatic cbt_sample(input logic [6:0] ca, input int gap);
        wait_cyc(1);
        ca_pin <= ca;
        cs_pin <= 1'b1;
        wait_cyc(1);
        cs_pin <= 1'b0;
        wait_cyc(gap);
    endtask
    task automatic cbt_exit();
        wait_cyc(3);
        cke_pin <= 1'b1;
        wait_cyc(1);
        dqs_pin <= 1'b0;
        wait_cyc(8);
    endtask
    task automatic wl_pulse(input int n);
        wait_cyc(20);
        dqs_pin <= 1'b0;
        wait_cyc(20);
        repeat (n) begin
            dqs_pin <= ~dqs_pin;
            wait_cyc(4);
        end
        wait_cyc(8);
    endtask
endmodule

// File: testbench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    logic       core_clk, rstn, cke_pin, cs_pin, dqs_pin;
    logic       cbt_mode, wl_mode, odt_on;
    logic [6:0] ca_pin, dq_out, dq_oe_n, ca_a;
    int         error_cnt, samples_checked;
    dtm_ctrl_model ctrl (.core_clk, .cke_pin, .cs_pin, .ca_pin, .dqs_pin,
        .cbt_mode, .wl_mode);
    dtm_core DUT (.core_clk, .rstn, .cke_pin, .cs_pin, .ca_pin, .dqs_pin,
        .cbt_mode, .wl_mode, .dq_out, .dq_oe_n, .odt_on);
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    task automatic check(input logic [6:0] seen, input logic [6:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    function automatic logic [6:0] exp_level(input logic hit);
        return {7{hit}};
    endfunction
    task automatic do_reset(input int n);
        ctrl.wait_cyc(1);
        rstn <= 1'b0;
        ctrl.wait_cyc(n);
        rstn <= 1'b1;
        ctrl.wait_cyc(1);
        #1;
        check(dq_oe_n, 7'h7f);
        check({6'h00, odt_on}, 7'h00);
        check(dq_out, 7'h00);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        ctrl.wait_cyc(2000);
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        rstn = 1'b0;
        error_cnt = 0;
        samples_checked = 0;
        void'($urandom(32'h02b9));
        do_reset(7);
        ctrl.set_mode(1'b1, 1'b0);
        ctrl.cbt_enter();
        #1;
        check({6'h00, odt_on}, 7'h01);
        for (int i = 0; i < 8; i++) begin
            ca_a = (i == 0) ? 7'h7f : (i == 1) ? 7'h00 : 7'($urandom);
            ctrl.cbt_sample(ca_a, 7 + int'($urandom % 4));
            #1;
            check(dq_out, ca_a);
            check(dq_oe_n, 7'h00);
        end
        // back-to-back samples: the last one stays on the lines
        ctrl.cbt_sample(~ca_a, 0);
        ctrl.cbt_sample(ca_a ^ 7'h55, 7);
        #1;
        check(dq_out, ca_a ^ 7'h55);
        $display("test training samples done");
        ctrl.cbt_exit();
        #1;
        check(dq_oe_n, 7'h7f);
        check({6'h00, odt_on}, 7'h00);
        ctrl.set_mode(1'b0, 1'b0);
        $display("test training exit done");
        ctrl.set_mode(1'b0, 1'b1);
        ctrl.wl_pulse(3);
        #1;
        check(dq_out, exp_level(1'b1));
        check(dq_oe_n, 7'h00);
        $display("test leveling done");
        // reset while the data lines are driven must release them
        do_reset(2);
        ctrl.set_mode(1'b0, 1'b0);
        $display("test reset done");
        tally_and_finish();
    end
endmodule
